// File: erc_pkg.sv
// erc_pkg: constants for the enclave re-entry checker.
// assumes a 32-bit apb register port and one core clock domain.
package erc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_LEAF    = 8'h00;
  localparam logic [7:0] REG_CTRL    = 8'h04;
  localparam logic [7:0] REG_PAGE    = 8'h08;
  localparam logic [7:0] REG_AEP_LO  = 8'h0C;
  localparam logic [7:0] REG_AEP_HI  = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_XCR_LO  = 8'h18;
  localparam logic [7:0] REG_XCR_HI  = 8'h1C;
  // field positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_OPT_OUT = 1;
  localparam int ST_BUSY      = 0;
  localparam int ST_GP        = 1;
  localparam int ST_PF        = 2;
  localparam int ST_ENCL      = 3;
  localparam int ST_BADLEAF   = 4;
  localparam int ST_PERF60    = 5;
  localparam int ST_PERF63    = 6;
  localparam int ST_IDX_LSB   = 8;
  // leaf code that selects re-entry
  localparam logic [7:0] LEAF_RESUME = 8'h03;
  // reset values
  localparam logic [7:0]  LEAF_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // check order, one index per check
  localparam int NCHK = 18;
  localparam logic [4:0] CK_DS = 5'h00, CK_BASES = 5'h01, CK_ALIGN = 5'h02;
  localparam logic [4:0] CK_CACHE = 5'h03, CK_AEP = 5'h04, CK_BUSY = 5'h05;
  localparam logic [4:0] CK_VALID = 5'h06, CK_PENDMOD = 5'h07, CK_ADDRTYPE = 5'h08;
  localparam logic [4:0] CK_SSAOFS = 5'h09, CK_FSGSOFS = 5'h0A, CK_FLAGS = 5'h0B;
  localparam logic [4:0] CK_INIT = 5'h0C, CK_MODE = 5'h0D, CK_XSTATE_FEATURE_MASK = 5'h0E;
  localparam logic [4:0] CK_XHDR = 5'h0F, CK_FRAME = 5'h10, CK_FSGSDS = 5'h11;
  localparam logic [4:0] CK_LAST = 5'h11;
  // checks that give a page fault instead of a protection fault
  localparam logic [NCHK-1:0] PF_MASK = 18'h001C8;
  // segment attribute bits, page layout and field masks
  localparam int SEG_S = 12, SEG_B11 = 11, SEG_B10 = 10;
  localparam int PAGE_LSB = 12;
  localparam int VA_MSB = 47;
  localparam logic [63:0] FLAGS_RSVD = 64'hFFFF_FFFF_FFFF_FFFC;
  localparam logic [63:0] XSTATE_FEATURE_MASK_LEGACY = 64'h0000_0000_0000_0003;
  localparam logic [31:0] LIMIT_4G = 32'hFFFF_FFFF;
  localparam logic [11:0] PAGE_OFS_ZERO = 12'h000;
  localparam logic [7:0]  TYPE_THREAD = 8'h01;
  // global performance status bits set on suppression
  localparam int PERF_BIT_A = 60;
  localparam int PERF_BIT_B = 63;
  // checker states
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_COMMIT} erc_state_e;
endpackage : erc_pkg

// File: erc_reentry_checker.sv
// erc_reentry_checker: ordered checks and state switch for enclave re-entry.
// assumes core-state inputs come from logic on clk_i and hold still while busy.
// Operation
// [RULE1] leaf 03h selects re-entry, page and pointer
// [RULE2] outside wide mode, unusable/expand-down data faults
// [RULE3] outside wide mode, nonzero bases or small stack fault
// [RULE4] control page not 4KByte aligned faults
// [RULE5] page outside protected cache gives page fault
// [RULE6] wide mode: non-canonical exit pointer faults
// [RULE7] page busy in another instruction faults
// [RULE8] entry invalid or blocked gives page fault
// [RULE9] entry pending or modified gives page fault
// [RULE10] wrong address or page type gives page fault
// [RULE11] save-area offset unaligned faults
// [RULE12] fs or gs offset unaligned faults
// [RULE13] reserved flags bits set faults
// [RULE14] enclave not initialized faults
// [RULE15] mode differs from enclave attribute faults
// [RULE16] feature mask illegal for xstate setting faults
// [RULE17] bad xstate header bytes or vector faults
// [RULE18] frame invalid or in use faults
// [RULE19] fs or gs outside data segment faults; the code checks this only outside wide mode
// [RULE20] success stores pointer, saves segments, swaps control
// [RULE21] opt-out clears trap flag; opt-in pends step
// [RULE22] opt-out suppresses monitoring, sets bits 60, 63
// [RULE23] checks in order; first failure changes nothing
`timescale 1ns/1ps
module erc_reentry_checker
  import erc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // segment state from the core
  input  wire logic        long_mode_active_i,
  input  wire logic        cs_long_i,
  input  wire logic        ds_usable_i,
  input  wire logic [15:0] ds_attr_i,
  input  wire logic [31:0] ds_limit_i,
  input  wire logic [31:0] cs_base_i,
  input  wire logic [31:0] ds_base_i,
  input  wire logic        es_usable_i,
  input  wire logic [31:0] es_base_i,
  input  wire logic        ss_usable_i,
  input  wire logic [31:0] ss_base_i,
  input  wire logic        ss_big_i,
  // control page lookup and page map entry
  input  wire logic        page_in_cache_i,
  input  wire logic        page_busy_i,
  input  wire logic        pme_valid_i,
  input  wire logic        pme_blocked_i,
  input  wire logic        pme_pending_i,
  input  wire logic        pme_modified_i,
  input  wire logic [31:0] pme_addr_i,
  input  wire logic [7:0]  pme_type_i,
  // control page fields
  input  wire logic [31:0] save_area_offset_i,
  input  wire logic [31:0] fs_base_offset_i,
  input  wire logic [31:0] gs_base_offset_i,
  input  wire logic [31:0] fs_limit_i,
  input  wire logic [31:0] gs_limit_i,
  input  wire logic [63:0] page_flags_i,
  input  wire logic        frame_valid_i,
  input  wire logic        frame_in_use_i,
  // enclave control structure and extended state
  input  wire logic        enclave_init_i,
  input  wire logic        wide_mode_attr_i,
  input  wire logic [31:0] enclave_base_i,
  input  wire logic [63:0] xstate_feature_mask_i,
  input  wire logic        os_xstate_enable_i,
  input  wire logic [63:0] ext_feature_ctrl_i,
  input  wire logic [63:0] xhdr_vector_i,
  input  wire logic [127:0] xhdr_reserved_i,
  // trap flag and monitoring state
  input  wire logic        tf_i,
  input  wire logic        perf_active_i,
  input  wire logic        enclave_exit_i,
  // results to the core
  output logic             fault_gp_o,
  output logic             fault_pf_o,
  output logic [31:0]      fault_addr_o,
  output logic             save_seg_o,
  output logic             xcr_load_o,
  output logic [63:0]      xcr_value_o,
  output logic             tf_force_clear_o,
  output logic             single_step_pend_o,
  output logic             perf_suppress_o,
  output logic [63:0]      perf_status_set_o,
  output logic             in_enclave_o
);

  erc_state_e        state;        // checker sequencer
  logic [4:0]        idx;          // check now being evaluated
  logic [7:0]        leaf;         // leaf selector
  logic              opt_out;      // entry kind for the next start
  logic [31:0]       page_addr;    // control page address
  logic [63:0]       async_exit_pointer;          // exit pointer operand
  logic [63:0]       aep_save;     // pointer kept for async exits
  logic [63:0]       xcr_saved;    // control value before entry
  logic              entry_out;    // entry kind of the live entry
  logic              perf60;       // sticky status bit
  logic              perf63;       // sticky status bit
  logic              bad_leaf;     // start seen with a wrong leaf
  logic [NCHK-1:0]   fail;         // one failure bit per check
  logic              wide;         // 64-bit mode now
  logic [31:0]       fs_lo, fs_hi, gs_lo, gs_hi;
  logic              wr, rd, start, clr_perf;

  // apb decode; zero wait states so each access ends in its first access cycle
  assign pready_o = 1'b1;
  assign wr       = psel_i && penable_i && pwrite_i;
  assign rd       = psel_i && penable_i && !pwrite_i;
  assign start    = wr && (paddr_i == REG_CTRL) && pwdata_i[CTRL_START];
  assign clr_perf = wr && (paddr_i == REG_STATUS);

  // wide mode needs both long mode active and a long code segment
  assign wide  = long_mode_active_i && cs_long_i;
  assign fs_lo = fs_base_offset_i + enclave_base_i;
  assign fs_hi = fs_lo + fs_limit_i;
  assign gs_lo = gs_base_offset_i + enclave_base_i;
  assign gs_hi = gs_lo + gs_limit_i;

  // all failure conditions at once; the sequencer reads them in order
  always_comb begin
    fail = '0;
    fail[CK_DS] = !wide && (!ds_usable_i || (ds_attr_i[SEG_S] &&
                  !ds_attr_i[SEG_B11] && ds_attr_i[SEG_B10]));        // [RULE2]
    fail[CK_BASES] = !wide && ((cs_base_i != WORD_RST) || (ds_base_i != WORD_RST)
                  || (es_usable_i && (es_base_i != WORD_RST))
                  || (ss_usable_i && ((ss_base_i != WORD_RST) || !ss_big_i))); // [RULE3]
    fail[CK_ALIGN] = page_addr[PAGE_LSB-1:0] != PAGE_OFS_ZERO;        // [RULE4]
    fail[CK_CACHE] = !page_in_cache_i;                                // [RULE5]
    fail[CK_AEP] = wide && (async_exit_pointer[63:VA_MSB] != {(64-VA_MSB){async_exit_pointer[VA_MSB]}}); // [RULE6]
    fail[CK_BUSY] = page_busy_i;                                      // [RULE7]
    fail[CK_VALID] = !pme_valid_i || pme_blocked_i;                   // [RULE8]
    fail[CK_PENDMOD] = pme_pending_i || pme_modified_i;               // [RULE9]
    fail[CK_ADDRTYPE] = (pme_addr_i != page_addr) || (pme_type_i != TYPE_THREAD); // [RULE10]
    fail[CK_SSAOFS] = save_area_offset_i[PAGE_LSB-1:0] != PAGE_OFS_ZERO; // [RULE11]
    fail[CK_FSGSOFS] = (fs_base_offset_i[PAGE_LSB-1:0] != PAGE_OFS_ZERO)
                  || (gs_base_offset_i[PAGE_LSB-1:0] != PAGE_OFS_ZERO); // [RULE12]
    fail[CK_FLAGS] = (page_flags_i & FLAGS_RSVD) != 64'h0;            // [RULE13]
    fail[CK_INIT] = !enclave_init_i;                                  // [RULE14]
    fail[CK_MODE] = wide != wide_mode_attr_i;                         // [RULE15]
    // with xstate saving off only the legacy pair is legal
    fail[CK_XSTATE_FEATURE_MASK] = os_xstate_enable_i
                  ? ((xstate_feature_mask_i & ext_feature_ctrl_i) != xstate_feature_mask_i)
                  : (xstate_feature_mask_i != XSTATE_FEATURE_MASK_LEGACY);           // [RULE16]
    fail[CK_XHDR] = (xhdr_reserved_i != 128'h0)
                  || ((xhdr_vector_i & ~xstate_feature_mask_i) != 64'h0); // [RULE17]
    fail[CK_FRAME] = !frame_valid_i || frame_in_use_i;                // [RULE18]
    // a wrapped segment is only contained when the data segment spans 4G
    fail[CK_FSGSDS] = !wide && (((fs_hi < fs_lo) ? (ds_limit_i != LIMIT_4G)
                                                 : (fs_hi > ds_limit_i))
                             || ((gs_hi < gs_lo) ? (ds_limit_i != LIMIT_4G)
                                                 : (gs_hi > ds_limit_i))); // [RULE19]
  end

  // sequencer: one check a cycle, stop at the first failure
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      idx   <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // a wrong leaf leaves the sequencer idle
          if (start && leaf == LEAF_RESUME) begin                     // [RULE1]
            state <= ST_CHECK;
            idx   <= CK_DS;
          end
        end
        ST_CHECK: begin
          if (fail[idx]) begin
            state <= ST_IDLE;                                         // [RULE23]
          end else if (idx == CK_LAST) begin
            state <= ST_COMMIT;
          end else begin
            idx <= idx + 5'h01;                                       // [RULE23]
          end
        end
        ST_COMMIT: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // fault pulses and held fault address, one cycle after the failing check
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_gp_o   <= 1'b0;
      fault_pf_o   <= 1'b0;
      fault_addr_o <= WORD_RST;
    end else begin
      fault_gp_o <= (state == ST_CHECK) && fail[idx] && !PF_MASK[idx];
      fault_pf_o <= (state == ST_CHECK) && fail[idx] && PF_MASK[idx];  // [RULE5]
      if (state == ST_CHECK && fail[idx]) begin
        fault_addr_o <= PF_MASK[idx] ? page_addr : WORD_RST;
      end
    end
  end

  // software registers; operands are frozen while checks run
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      leaf      <= LEAF_RST;
      opt_out   <= 1'b0;
      page_addr <= WORD_RST;
      async_exit_pointer       <= 64'h0;
    end else if (wr && state == ST_IDLE) begin
      unique case (paddr_i)
        REG_LEAF:   leaf <= pwdata_i[7:0];
        REG_CTRL:   opt_out <= pwdata_i[CTRL_OPT_OUT];
        REG_PAGE:   page_addr <= pwdata_i;                            // [RULE1]
        REG_AEP_LO: async_exit_pointer[31:0] <= pwdata_i;                            // [RULE1]
        REG_AEP_HI: async_exit_pointer[63:32] <= pwdata_i;
        default:    ;
      endcase
    end
  end

  // committed state; only a full pass sets it, and an enclave exit clears in_enclave_o
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aep_save     <= 64'h0;
      xcr_saved    <= 64'h0;
      xcr_value_o  <= 64'h0;
      entry_out    <= 1'b0;
      in_enclave_o <= 1'b0;
    end else if (state == ST_COMMIT) begin
      aep_save     <= async_exit_pointer;                                            // [RULE20]
      entry_out    <= opt_out;
      in_enclave_o <= 1'b1;
      if (os_xstate_enable_i) begin
        xcr_saved   <= ext_feature_ctrl_i;                            // [RULE20]
        xcr_value_o <= xstate_feature_mask_i;
      end
    end else if (enclave_exit_i) begin
      in_enclave_o <= 1'b0;
    end
  end

  // entry pulses
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      save_seg_o         <= 1'b0;
      xcr_load_o         <= 1'b0;
      single_step_pend_o <= 1'b0;
      perf_status_set_o  <= 64'h0;
    end else begin
      save_seg_o <= state == ST_COMMIT;                               // [RULE20]
      xcr_load_o <= state == ST_COMMIT && os_xstate_enable_i;         // [RULE20]
      // opt-in with the trap flag set takes a step right after entry
      single_step_pend_o <= state == ST_COMMIT && !opt_out && tf_i;   // [RULE21]
      perf_status_set_o <= '0;
      if (state == ST_COMMIT && opt_out && perf_active_i) begin
        perf_status_set_o[PERF_BIT_A] <= 1'b1;                        // [RULE22]
        perf_status_set_o[PERF_BIT_B] <= 1'b1;
      end
    end
  end

  // opt-out keeps trap flag clear and monitoring suppressed inside
  assign tf_force_clear_o = in_enclave_o && entry_out;                // [RULE21]
  // fixed counters 1 and 2 stay outside this suppression
  assign perf_suppress_o  = in_enclave_o && entry_out;                // [RULE22]

  // sticky status: hardware set wins over a software clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      perf60   <= 1'b0;
      perf63   <= 1'b0;
      bad_leaf <= 1'b0;
    end else begin
      if (perf_status_set_o[PERF_BIT_A]) perf60 <= 1'b1;
      else if (clr_perf && pwdata_i[ST_PERF60]) perf60 <= 1'b0;
      if (perf_status_set_o[PERF_BIT_B]) perf63 <= 1'b1;
      else if (clr_perf && pwdata_i[ST_PERF63]) perf63 <= 1'b0;
      if (start && leaf != LEAF_RESUME) bad_leaf <= 1'b1;
      else if (clr_perf && pwdata_i[ST_BADLEAF]) bad_leaf <= 1'b0;
    end
  end

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    prdata_o  = WORD_RST;
    pslverr_o = 1'b0;
    if (rd || wr) begin
      unique case (paddr_i)
        REG_LEAF:   prdata_o = {24'h0, leaf};
        REG_CTRL:   prdata_o = {30'h0, opt_out, 1'b0};
        REG_PAGE:   prdata_o = page_addr;
        REG_AEP_LO: prdata_o = aep_save[31:0];
        REG_AEP_HI: prdata_o = aep_save[63:32];
        REG_STATUS: begin
          prdata_o[ST_BUSY]    = state != ST_IDLE;
          prdata_o[ST_GP]      = fault_gp_o;
          prdata_o[ST_PF]      = fault_pf_o;
          prdata_o[ST_ENCL]    = in_enclave_o;
          prdata_o[ST_BADLEAF] = bad_leaf;
          prdata_o[ST_PERF60]  = perf60;
          prdata_o[ST_PERF63]  = perf63;
          prdata_o[ST_IDX_LSB +: 5] = idx;
        end
        REG_XCR_LO: prdata_o = xcr_saved[31:0];
        REG_XCR_HI: prdata_o = xcr_saved[63:32];
        default:    pslverr_o = 1'b1;
      endcase
      if (!rd) prdata_o = WORD_RST;
    end
  end

  // checks on the sequencer and its results
  sequence s_fail_now;
    state == ST_CHECK && fail[idx];
  endsequence
  sequence s_pass_now;
    state == ST_CHECK && !fail[idx];
  endsequence

  chk_leaf_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE1]
    (state == ST_IDLE && start && leaf != LEAF_RESUME) |=> state == ST_IDLE)
    else $error("start with wrong leaf began checks");
  chk_align_fault: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE4]
    (state == ST_CHECK && idx == CK_ALIGN && page_addr[11:0] != 12'h000)
    |=> fault_gp_o && !fault_pf_o)
    else $error("unaligned page gave no protection fault");
  chk_pf_kind: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE8]
    (s_fail_now and (idx == CK_VALID)) |=> fault_pf_o && fault_addr_o == $past(page_addr))
    else $error("invalid entry gave no page fault");
  chk_gp_kind: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE13]
    (s_fail_now and (idx == CK_FLAGS)) |=> fault_gp_o ##1 !fault_gp_o)
    else $error("reserved flags gave no single fault pulse");
  chk_order_step: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE23]
    (s_pass_now and (idx != CK_LAST)) |=> state == ST_CHECK && idx == $past(idx) + 5'h01)
    else $error("checks skipped or reordered");
  chk_fail_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE23]
    s_fail_now |=> !save_seg_o && !xcr_load_o ##1 !save_seg_o && state != ST_COMMIT)
    else $error("state changed after a failing check");
  chk_full_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE20]
    (s_pass_now and (idx == CK_LAST)) |=> state == ST_COMMIT
    ##1 save_seg_o && aep_save == $past(async_exit_pointer, 2))
    else $error("full pass did not commit the exit pointer");
  chk_xcr_swap: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE20]
    (state == ST_COMMIT && os_xstate_enable_i)
    |=> xcr_load_o && xcr_value_o == $past(xstate_feature_mask_i))
    else $error("control register not loaded with mask");
  chk_trap_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE21]
    (state == ST_COMMIT && opt_out) |=> tf_force_clear_o && !single_step_pend_o)
    else $error("opt-out entry left trap flag free");
  chk_perf_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE22]
    (state == ST_COMMIT && opt_out && perf_active_i)
    |=> perf_status_set_o[60] && perf_status_set_o[63] ##1 perf60 && perf63)
    else $error("suppression did not set status bits");

endmodule : erc_reentry_checker

// File: test_erc_reentry_checker.sv
// test_erc_reentry_checker: self-checking bench for the re-entry checker.
// assumes erc_pkg is compiled first; design assertions live in the design.
`timescale 1ns/1ps
module test_erc_reentry_checker
  import erc_pkg::*;
;
  localparam logic [31:0] PAGE_OK = 32'h0001_0000;     // aligned control page
  localparam logic [18:0] PF_EXP  = 19'h000E8;          // cases that end in a page fault
  logic clk_i = 1'b0, arst_n_i = 1'b0, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i, pme_type_i;
  logic [31:0] pwdata_i, prdata_o, ds_limit_i, cs_base_i, ds_base_i, es_base_i, ss_base_i;
  logic [31:0] pme_addr_i, save_area_offset_i, fs_base_offset_i, gs_base_offset_i;
  logic [31:0] fs_limit_i, gs_limit_i, enclave_base_i, fault_addr_o;
  logic [15:0] ds_attr_i;
  logic [63:0] page_flags_i, xstate_feature_mask_i, ext_feature_ctrl_i, xhdr_vector_i;
  logic [63:0] xcr_value_o, perf_status_set_o;
  logic [127:0] xhdr_reserved_i;
  logic long_mode_active_i, cs_long_i, ds_usable_i, es_usable_i, ss_usable_i, ss_big_i;
  logic page_in_cache_i, page_busy_i, pme_valid_i, pme_blocked_i, pme_pending_i;
  logic pme_modified_i, frame_valid_i, frame_in_use_i, enclave_init_i, wide_mode_attr_i;
  logic os_xstate_enable_i, tf_i, perf_active_i, enclave_exit_i, fault_gp_o, fault_pf_o;
  logic save_seg_o, xcr_load_o, tf_force_clear_o, single_step_pend_o, perf_suppress_o;
  logic in_enclave_o;
  int   err_count = 0;                                  // mismatches seen
  int   tests_run = 0;                                  // comparisons made

  always #10 clk_i = ~clk_i;                            // 50 MHz core clock

  erc_reentry_checker DUT (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .long_mode_active_i, .cs_long_i,
    .ds_usable_i, .ds_attr_i, .ds_limit_i, .cs_base_i, .ds_base_i, .es_usable_i, .es_base_i,
    .ss_usable_i, .ss_base_i, .ss_big_i, .page_in_cache_i, .page_busy_i, .pme_valid_i,
    .pme_blocked_i, .pme_pending_i, .pme_modified_i, .pme_addr_i, .pme_type_i,
    .save_area_offset_i, .fs_base_offset_i, .gs_base_offset_i, .fs_limit_i, .gs_limit_i,
    .page_flags_i, .frame_valid_i, .frame_in_use_i, .enclave_init_i, .wide_mode_attr_i,
    .enclave_base_i, .xstate_feature_mask_i, .os_xstate_enable_i, .ext_feature_ctrl_i,
    .xhdr_vector_i, .xhdr_reserved_i, .tf_i, .perf_active_i, .enclave_exit_i, .fault_gp_o,
    .fault_pf_o, .fault_addr_o, .save_seg_o, .xcr_load_o, .xcr_value_o, .tf_force_clear_o,
    .single_step_pend_o, .perf_suppress_o, .perf_status_set_o, .in_enclave_o);

  // compare and count; four-state compare so unknowns never match
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; setup after the next edge, returns just after the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_i);                                   // idle edge keeps release and setup apart
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) err_count++;
    rd = prdata_o;                                      // taken at the edge pready is seen
    er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // a core state that passes every check outside wide mode
  task automatic set_good();
    long_mode_active_i <= 1'b0; cs_long_i <= 1'b0; wide_mode_attr_i <= 1'b0;
    ds_usable_i <= 1'b1; ds_attr_i <= 16'h1000; ds_limit_i <= 32'hFFFF_FFFF;
    cs_base_i <= '0; ds_base_i <= '0; es_base_i <= '0; ss_base_i <= '0;
    es_usable_i <= 1'b1; ss_usable_i <= 1'b1; ss_big_i <= 1'b1;
    page_in_cache_i <= 1'b1; page_busy_i <= 1'b0; pme_valid_i <= 1'b1; pme_blocked_i <= 1'b0;
    pme_pending_i <= 1'b0; pme_modified_i <= 1'b0; pme_addr_i <= PAGE_OK; pme_type_i <= 8'h01;
    save_area_offset_i <= 32'h0000_1000; fs_base_offset_i <= '0; gs_base_offset_i <= '0;
    fs_limit_i <= 32'h0002_0000; gs_limit_i <= 32'h0002_0000; page_flags_i <= '0;
    frame_valid_i <= 1'b1; frame_in_use_i <= 1'b0; enclave_init_i <= 1'b1;
    enclave_base_i <= '0; xstate_feature_mask_i <= 64'h3; os_xstate_enable_i <= 1'b1;
    ext_feature_ctrl_i <= 64'h7; xhdr_vector_i <= 64'h1; xhdr_reserved_i <= '0;
    tf_i <= 1'b1; perf_active_i <= 1'b1; enclave_exit_i <= 1'b0;
  endtask : set_good

  // break exactly one check (case 2 also breaks the address check, case 13 the header check; case 18 breaks two to probe the order)
  task automatic brk(input int k);
    case (k)
      0:  ds_usable_i <= 1'b0;
      1:  ss_big_i <= 1'b0;
      3:  page_in_cache_i <= 1'b0;
      4:  page_busy_i <= 1'b1;
      5:  pme_blocked_i <= 1'b1;
      6:  pme_modified_i <= 1'b1;
      7:  pme_type_i <= 8'h02;
      8:  save_area_offset_i <= 32'h0000_1010;
      9:  gs_base_offset_i <= 32'h0000_0800;
      10: page_flags_i <= 64'h20;
      11: enclave_init_i <= 1'b0;
      12: wide_mode_attr_i <= 1'b1;
      13: xstate_feature_mask_i <= 64'h8;
      14: xhdr_reserved_i <= 128'h1;
      15: frame_in_use_i <= 1'b1;
      16: ds_limit_i <= 32'h0000_FFFF;
      17: begin
        long_mode_active_i <= 1'b1; cs_long_i <= 1'b1; wide_mode_attr_i <= 1'b1;
      end
      18: begin
        ds_usable_i <= 1'b0; page_in_cache_i <= 1'b0;
      end
      default: ;                                        // case 2 breaks the page address
    endcase
  endtask : brk

  // run one start; write the page, exit pointer and control registers
  task automatic launch(input logic [31:0] pg, input logic [31:0] hi, input logic opt);
    wr(REG_PAGE, pg);
    wr(REG_AEP_LO, 32'h0000_4000);
    wr(REG_AEP_HI, hi);
    wr(REG_CTRL, {30'h0, opt, 1'b1});
  endtask : launch

  task automatic t_fault(input int k);
    logic gp, pf, sv;
    logic [31:0] ad, pg;
    gp = 1'b0; pf = 1'b0; sv = 1'b0; ad = '1;
    pg = (k == 2) ? PAGE_OK + 32'h100 : PAGE_OK;
    set_good();
    @(posedge clk_i);
    brk(k);
    launch(pg, (k == 17) ? 32'h0001_0000 : 32'h0, 1'b1);
    for (int n = 0; n < 40 && !(gp | pf); n++) begin
      @(posedge clk_i);
      #1;
      sv = sv | save_seg_o;
      gp = fault_gp_o;
      pf = fault_pf_o;
      ad = fault_addr_o;
    end
    check({gp, pf}, PF_EXP[k] ? 2'b01 : 2'b10);
    check(ad, PF_EXP[k] ? pg : 32'h0);
    check({sv, in_enclave_o}, 2'b00);
    @(posedge clk_i);
  endtask : t_fault

  task automatic t_entry(input logic opt);
    logic sv, xl, ss;
    logic [63:0] pst;
    logic [31:0] r;
    logic e;
    sv = 1'b0; xl = 1'b0; ss = 1'b0; pst = '0;
    set_good();
    launch(PAGE_OK, 32'h0, opt);
    for (int n = 0; n < 40 && !sv; n++) begin
      @(posedge clk_i);
      #1;
      sv = save_seg_o;
      xl = xl | xcr_load_o;
      ss = ss | single_step_pend_o;
      pst = pst | perf_status_set_o;
    end
    check({sv, xl, in_enclave_o}, 3'b111);
    check(xcr_value_o, 64'h3);
    check(pst, opt ? 64'h9000_0000_0000_0000 : 64'h0);
    check({tf_force_clear_o, perf_suppress_o}, {opt, opt});
    @(posedge clk_i);
    check(ss | single_step_pend_o, !opt);
    apb(1'b0, REG_AEP_LO, 32'h0, r, e);
    check(r, 32'h0000_4000);
    apb(1'b0, REG_XCR_LO, 32'h0, r, e);
    check(r, 32'h0000_0007);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check(r[6:3], opt ? 4'b1101 : 4'b0001);
    wr(REG_STATUS, 32'h0000_0060);
    enclave_exit_i <= 1'b1;
    @(posedge clk_i);
    enclave_exit_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check(in_enclave_o, 1'b0);
    @(posedge clk_i);
  endtask : t_entry

  // reset values, an unmapped read, and a leaf other than re-entry
  task automatic t_leaf();
    logic [31:0] r;
    logic e;
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({e, r}, {1'b1, 32'h0});
    set_good();
    wr(REG_LEAF, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (25) @(posedge clk_i);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check({r[4], r[3:0]}, 5'b10000);
    wr(REG_STATUS, 32'h0000_0010);
    wr(REG_LEAF, {24'h0, LEAF_RESUME});
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check(r[4], 1'b0);
  endtask : t_leaf

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // the whole run takes about 600 cycles; the watchdog allows over sixteen times that
  initial begin
    repeat (10000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = '0; pwdata_i = '0;
    set_good();
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_leaf();
    for (int k = 0; k < 19; k++) begin
      t_fault(k);
    end
    t_entry(1'b1);
    t_entry(1'b0);
    wrap_up();
  end
endmodule : test_erc_reentry_checker
